// ---- voltage_detector_top.sv ----
/*
  Digital control of the supply voltage detector: control register, settling,
  trip qualification, sticky detect flag, interrupt and wake request.
  Assumes a comparator outside that reports supply below trip point as a level
  synchronous to ref_clk, and a bandgap-ready level likewise synchronous.
*/
`timescale 1ns/1ps
module voltage_detector_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [voltage_detector_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Analog front end
  input wire logic cmp_below,
  input wire logic bandgap_ready,
  output logic analog_power,
  output logic [3:0] tap_select,
  output logic external_trip_input_sel,
  // System
  input wire logic sleep_mode,
  output logic wake_request,
  output logic irq
);
  import voltage_detector_pkg::*;

  logic [7:0] control;
  logic [7:0] next_control;
  logic detect_event_flag;
  logic next_detect_event_flag;
  logic detect_event_irq_enable;
  logic next_detect_event_irq_enable;
  logic global_irq_enable;
  logic next_global_irq_enable;
  logic [7:0] next_rdata;
  logic settled;
  logic trip_hit;
  logic trip_prev;
  logic next_trip_prev;
  logic trip_edge;
  logic enable;
  logic [3:0] level;
  voltage_detector_state_t state;
  voltage_detector_state_t next_state;

  assign enable = control[BIT_ENABLE];
  assign level = control[LVL_MSB:0];

  voltage_detector_settle #(
    .CYCLES(SETTLE_CYCLES)
  ) u_settle (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .start(enable),
    .done(settled)
  );

  // Analog steering
  assign analog_power = enable;
  assign tap_select = level;
  assign external_trip_input_sel = enable && (level == LEVEL_EXTERNAL);

  // Direction decides which comparator level counts as a trip
  assign trip_hit = control[BIT_DIR] ? !cmp_below : cmp_below;
  // Edge so a standing condition after a clear does not re-raise every cycle
  assign trip_edge = trip_hit && !trip_prev;

  always_comb begin
    next_state = state;
    case (state)
      DET_OFF: begin
        if (enable) begin
          next_state = DET_SETTLE;
        end
      end
      DET_SETTLE: begin
        if (!enable) begin
          next_state = DET_OFF;
        end else if (settled) begin
          next_state = DET_ARMED;
        end
      end
      DET_ARMED: begin
        if (!enable) begin
          next_state = DET_OFF;
        end
      end
      default: begin
        next_state = DET_OFF;
      end
    endcase
  end

  always_comb begin
    next_control = control;
    next_detect_event_flag = detect_event_flag;
    next_detect_event_irq_enable = detect_event_irq_enable;
    next_global_irq_enable = global_irq_enable;
    next_trip_prev = (state == DET_ARMED) ? trip_hit : 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_CONTROL: begin
          next_control = reg_wdata & WRITE_MASK_CONTROL;
        end
        ADDR_FLAGS: begin
          // Write one to clear
          if (reg_wdata[BIT_DETECT]) begin
            next_detect_event_flag = 1'b0;
          end
        end
        ADDR_ENABLES: begin
          next_detect_event_irq_enable = reg_wdata[BIT_DETECT];
        end
        ADDR_IRQ_CTRL: begin
          next_global_irq_enable = reg_wdata[BIT_GLOBAL];
        end
        default: begin
        end
      endcase
    end
    // Set wins over a same-cycle clear; sleep does not stop detection
    if (state == DET_ARMED && trip_edge) begin
      next_detect_event_flag = 1'b1;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CONTROL: begin
          next_rdata = control & WRITE_MASK_CONTROL;
          next_rdata[BIT_BANDGAP] = bandgap_ready;
          next_rdata[BIT_REF_STABLE] = (state == DET_ARMED);
        end
        ADDR_FLAGS: begin
          next_rdata[BIT_DETECT] = detect_event_flag;
        end
        ADDR_ENABLES: begin
          next_rdata[BIT_DETECT] = detect_event_irq_enable;
        end
        ADDR_IRQ_CTRL: begin
          next_rdata[BIT_GLOBAL] = global_irq_enable;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      control <= CONTROL_RESET;
      detect_event_flag <= 1'b0;
      detect_event_irq_enable <= 1'b0;
      global_irq_enable <= 1'b0;
      trip_prev <= 1'b0;
      state <= DET_OFF;
      reg_rdata <= 8'h00;
    end else begin
      control <= next_control;
      detect_event_flag <= next_detect_event_flag;
      detect_event_irq_enable <= next_detect_event_irq_enable;
      global_irq_enable <= next_global_irq_enable;
      trip_prev <= next_trip_prev;
      state <= next_state;
      reg_rdata <= next_rdata;
    end
  end

  // Wake needs only the peripheral enable; vectoring needs the global one too
  assign wake_request = sleep_mode && detect_event_flag && detect_event_irq_enable;
  assign irq = detect_event_flag && detect_event_irq_enable && global_irq_enable;
endmodule

// ---- voltage_detector_pkg.sv ----
/*
  Package for the voltage detector control block: register map, field positions,
  reset values and settling count.
  Assumes a 50 MHz ref_clk and an 8-bit register port.
*/
package voltage_detector_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned ADDR_W = 2;
  // Register indices on the plain register port
  localparam logic [1:0] ADDR_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_FLAGS = 2'h1;
  localparam logic [1:0] ADDR_ENABLES = 2'h2;
  localparam logic [1:0] ADDR_IRQ_CTRL = 2'h3;
  // Control register fields
  localparam int unsigned BIT_DIR = 7;
  localparam int unsigned BIT_BANDGAP = 6;
  localparam int unsigned BIT_REF_STABLE = 5;
  localparam int unsigned BIT_ENABLE = 4;
  localparam int unsigned LVL_MSB = 3;
  localparam logic [3:0] LEVEL_EXTERNAL = 4'hf;
  localparam logic [3:0] LEVEL_MIN = 4'h4;
  localparam logic [3:0] LEVEL_MAX = 4'he;
  // Flag and enable register field, global enable field
  localparam int unsigned BIT_DETECT = 2;
  localparam int unsigned BIT_GLOBAL = 7;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] WRITE_MASK_CONTROL = 8'h9f;
  // Settling time of the reference after enable, in ns
  localparam int unsigned SETTLE_NS = 25000;
  localparam int unsigned SETTLE_CYCLES = (SETTLE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned CNT_W = 16;
  // Detector sequencing states
  typedef enum logic [1:0] {DET_OFF, DET_SETTLE, DET_ARMED} voltage_detector_state_t;
endpackage

// ---- voltage_detector_settle.sv ----
/*
  Settling timer: counts a fixed interval after start, raises done.
  Assumes start held high while the detector is enabled.
*/
`timescale 1ns/1ps
module voltage_detector_settle #(
  parameter int unsigned CYCLES = voltage_detector_pkg::SETTLE_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Control
  input wire logic start,
  output logic done
);
  import voltage_detector_pkg::*;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic next_done;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  always_comb begin
    next_count = count;
    next_done = done;
    if (!start) begin
      next_count = '0;
      next_done = 1'b0;
    end else if (!done) begin
      // Fixed in time, not tied to any software clock setting
      if (count == LAST) begin
        next_done = 1'b1;
      end else begin
        next_count = count + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      count <= '0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      done <= next_done;
    end
  end
endmodule

// ---- voltage_detector_top_sva.sv ----
/* Checker on the ports of voltage_detector_top. Assumes one ref_clk domain, sync reset. */
`timescale 1ns/1ps
module voltage_detector_top_sva (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [voltage_detector_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Analog and system
  input wire logic bandgap_ready,
  input wire logic analog_power,
  input wire logic [3:0] tap_select,
  input wire logic sleep_mode,
  input wire logic wake_request,
  input wire logic irq
);
  import voltage_detector_pkg::*;
  logic [15:0] on_cnt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Cycles powered; saturates so a long run never wraps
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !analog_power) on_cnt <= 16'h0;
    else if (on_cnt != 16'hffff) on_cnt <= on_cnt + 16'h1;
  end
  sequence ctrl_wr_s;
    reg_wr && reg_addr == ADDR_CONTROL;
  endsequence
  power_follow_a: assert property (ctrl_wr_s |=> analog_power == $past(reg_wdata[4]))
    else $error("enable not followed");
  tap_follow_a: assert property (ctrl_wr_s |=> tap_select == $past(reg_wdata[3:0]))
    else $error("level not followed");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside slot");
  bandgap_read_a: assert property (reg_rd && reg_addr == ADDR_CONTROL |=>
    reg_rdata[6] == $past(bandgap_ready)) else $error("bandgap bit wrong");
  settle_gate_a: assert property ($rose(irq) && !$past(reg_wr) |->
    on_cnt >= SETTLE_CYCLES) else $error("flag before settled");
  flag_sticky_a: assert property (irq && !reg_wr |=> irq)
    else $error("flag dropped alone");
  sleep_wake_a: assert property (irq && sleep_mode |-> wake_request)
    else $error("no wake");
  reset_off_a: assert property (disable iff (1'b0) sys_rst |=> !analog_power && !irq)
    else $error("reset left detector on");
endmodule
bind voltage_detector_top voltage_detector_top_sva u_sva (.*);

// ---- voltage_detector_rail.sv ----
/* Supply rail model: comparator and bandgap levels. Assumes ref_clk. */
`timescale 1ns/1ps
module voltage_detector_rail (
  // Clock
  input wire logic ref_clk,
  // Test control
  input wire logic rail_low,
  input wire logic bg_ok,
  // Toward detector
  output logic cmp_below,
  output logic bandgap_ready
);
  // Registered, as the detector expects synchronous levels
  always_ff @(posedge ref_clk) begin
    cmp_below <= rail_low;
    bandgap_ready <= bg_ok;
  end
endmodule

// ---- voltage_detector_tb_top.sv ----
/* Testbench for voltage_detector_top. Assumes the rail model on the analog side. */
`timescale 1ns/1ps
`define CK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module voltage_detector_tb_top;
  import voltage_detector_pkg::*;
  logic ref_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, rail_low = 0, bg_ok = 1;
  logic sleep_mode = 0, cmp_below, bandgap_ready, analog_power;
  logic external_trip_input_sel, wake_request, irq;
  logic [1:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata;
  logic [3:0] tap_select;
  int error_cnt = 0, checked = 0, cycles = 0;
  voltage_detector_rail u_rail (.*);
  voltage_detector_top u_dut (.*);
  initial forever #10 ref_clk = ~ref_clk;
  // Run needs about 3000 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 12000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checked %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 0;
  endtask
  task automatic rc(input string n, input logic [1:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 0;
    #1 `CK(n, e, reg_rdata)
  endtask
  task automatic rail(input logic v, input int n);
    @(posedge ref_clk);
    rail_low <= v;
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 0;
    rc("ctrl", ADDR_CONTROL, 8'h40);
    rc("flags", ADDR_FLAGS, 8'h00);
    wr(ADDR_CONTROL, 8'h0e);
    wr(ADDR_CONTROL, 8'h1e);
    rc("settling", ADDR_CONTROL, 8'h5e);
    `CK("tap", 4'he, tap_select)
    rail(1, 20);
    rail(0, 1300);
    rc("armed", ADDR_CONTROL, 8'h7e);
    rc("missed", ADDR_FLAGS, 8'h00);
    wr(ADDR_FLAGS, 8'h04);
    wr(ADDR_ENABLES, 8'h04);
    wr(ADDR_IRQ_CTRL, 8'h80);
    $display("setup done");
    sleep_mode <= 1;
    rail(1, 3);
    `CK("irq", 1'b1, irq)
    rail(0, 3);
    `CK("sticky", 1'b1, irq)
    rc("flag", ADDR_FLAGS, 8'h04);
    wr(ADDR_IRQ_CTRL, 8'h00);
    rc("gie", ADDR_IRQ_CTRL, 8'h00);
    `CK("gie off", 1'b0, irq)
    `CK("wake", 1'b1, wake_request)
    wr(ADDR_FLAGS, 8'h04);
    rc("cleared", ADDR_FLAGS, 8'h00);
    `CK("wake off", 1'b0, wake_request)
    sleep_mode <= 0;
    $display("low trip done");
    wr(ADDR_CONTROL, 8'h0f);
    wr(ADDR_CONTROL, 8'h9f);
    wr(ADDR_IRQ_CTRL, 8'h80);
    rail(0, 1300);
    `CK("ext", 1'b1, external_trip_input_sel)
    `CK("high trip", 1'b1, irq)
    $display("high trip done");
    wr(ADDR_CONTROL, 8'h64);
    rc("ro bits", ADDR_CONTROL, 8'h44);
    `CK("off", 1'b0, analog_power)
    `CK("ext off", 1'b0, external_trip_input_sel)
    bg_ok <= 0;
    rc("bg low", ADDR_CONTROL, 8'h04);
    wr(ADDR_CONTROL, 8'h14);
    @(posedge ref_clk);
    sys_rst <= 1;
    @(posedge ref_clk);
    sys_rst <= 0;
    rc("rst ctrl", ADDR_CONTROL, 8'h00);
    `CK("rst irq", 1'b0, irq)
    $display("reset done");
    finish_test();
  end
endmodule
